//--- src/cra_alu_core.sv
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module cra_alu_core
    import cra_pkg::*;
#(
    parameter int PRE_W = CRA_PRE_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [CRA_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [CRA_DW-1:0] pwdata,
    output logic [CRA_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // wake pin, asynchronous
    input wire logic wake_pin,
    // port direction registers
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_c_direction,
    // power state
    output logic osc_run,
    output logic cpu_halted
);
    cra_state_e st_q, st_d;
    cra_cmd_s cmd_in, cmd_q, cmd_d;
    cra_flags_s flags_q, flags_d;
    logic [7:0] acc_q, acc_d;
    logic [6:0] faddr_q, faddr_d;
    logic [7:0] dir_a_q, dir_a_d, dir_b_q, dir_b_d, dir_c_q, dir_c_d;
    logic [CRA_DW-1:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic asleep_q, asleep_d, osc_q, osc_d;
    logic wake_meta_q, wake_s_q;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [7:0] wdog_q, wdog_d;
    logic mem_we;
    logic [6:0] mem_raddr, mem_waddr;
    logic [7:0] mem_wdata, mem_rdata;
    logic is_cmd, cmd_legal, reg_op, lit_op, exec_go, sleep_go, wr_res;
    logic borrow, flag_c;
    logic [7:0] opnd, res, cmd_lit;
    logic [8:0] diff;
    logic [4:0] nib;

    assign cmd_in = cra_cmd_s'(pwdata[CRA_CMD_W-1:0]);
    assign cmd_lit = cmd_in.lit;
    assign flag_c = flags_q.c;
    assign is_cmd = (paddr == CRA_OFF_CMD);

    cra_file_mem #(
        .AW(CRA_FAW),
        .DW(8)
    ) u_file (
        .clk(pclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // the wake pin is asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_meta_q <= 1'b0;
            wake_s_q <= 1'b0;
        end else begin
            wake_meta_q <= wake_pin;
            wake_s_q <= wake_meta_q;
        end
    end

    // command decode and datapath
    always_comb begin
        reg_op = cmd_in.op inside {OP_ROTATE_RIGHT_CARRY, OP_FILE_MINUS_ACC,
            OP_FILE_MINUS_ACC_BORROW, OP_NIBBLE_EXCHANGE, OP_XOR_FILE};
        lit_op = cmd_in.op inside {OP_LITERAL_MINUS_ACC, OP_XOR_LITERAL};
        cmd_legal = reg_op || lit_op || (cmd_in.op == OP_SLEEP) ||
            (cmd_in.op == OP_DIRECTION_LOAD &&
             cmd_in.faddr >= CRA_DIR_A && cmd_in.faddr <= CRA_DIR_C);
        exec_go = (st_q == ST_FETCH) && pwrite && is_cmd &&
            !asleep_q && cmd_legal;
        opnd = lit_op ? cmd_in.lit : mem_rdata;
        borrow = (cmd_in.op == OP_FILE_MINUS_ACC_BORROW) && !flags_q.c;
        diff = {1'b0, opnd} - {1'b0, acc_q} - {8'h00, borrow};
        nib = {1'b0, opnd[3:0]} - {1'b0, acc_q[3:0]} - {4'h0, borrow};
    end

    // bus, execution and power state
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        flags_d = flags_q;
        acc_d = acc_q;
        faddr_d = faddr_q;
        dir_a_d = dir_a_q;
        dir_b_d = dir_b_q;
        dir_c_d = dir_c_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        asleep_d = asleep_q;
        osc_d = osc_q;
        sleep_go = 1'b0;
        wr_res = 1'b0;
        res = 8'h00;
        mem_we = 1'b0;
        mem_waddr = cmd_in.faddr;
        mem_raddr = is_cmd ? cmd_in.faddr : faddr_q;
        if (asleep_q && wake_s_q) begin
            asleep_d = 1'b0;
            osc_d = 1'b1;
        end
        if (exec_go) begin
            cmd_d = cmd_in;
            unique case (cmd_in.op)
                OP_ROTATE_RIGHT_CARRY: begin
                    res = {flags_q.c, mem_rdata[7:1]};
                    flags_d.c = mem_rdata[0];
                    wr_res = 1'b1;
                end
                OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC,
                OP_FILE_MINUS_ACC_BORROW: begin
                    res = diff[7:0];
                    flags_d.c = !diff[8];
                    flags_d.half_borrow_flag = !nib[4];
                    flags_d.z = (diff[7:0] == 8'h00);
                    wr_res = 1'b1;
                end
                OP_NIBBLE_EXCHANGE: begin
                    res = {mem_rdata[3:0], mem_rdata[7:4]};
                    wr_res = 1'b1;
                end
                OP_XOR_LITERAL, OP_XOR_FILE: begin
                    res = acc_q ^ opnd;
                    flags_d.z = ((acc_q ^ opnd) == 8'h00);
                    wr_res = 1'b1;
                end
                OP_DIRECTION_LOAD: begin
                    unique case (cmd_in.faddr)
                        CRA_DIR_A: dir_a_d = acc_q;
                        CRA_DIR_B: dir_b_d = acc_q;
                        default: dir_c_d = acc_q;
                    endcase
                end
                OP_SLEEP: begin
                    sleep_go = 1'b1;
                    flags_d.expiry_flag_n = 1'b1;
                    flags_d.power_down_flag_n = 1'b0;
                    asleep_d = 1'b1;
                    osc_d = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // literal ops always land in the accumulator
        if (wr_res && reg_op && cmd_in.dest) begin
            mem_we = 1'b1;
        end else if (wr_res) begin
            acc_d = res;
        end
        mem_wdata = res;
        unique case (st_q)
            ST_IDLE: begin
                if (psel && !penable) begin
                    st_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                st_d = ST_DONE;
                pready_d = 1'b1;
                prdata_d = '0;
                if (pwrite) begin
                    unique case (paddr)
                        CRA_OFF_CMD: pslverr_d = !exec_go;
                        CRA_OFF_ACC: acc_d = pwdata[7:0];
                        CRA_OFF_STATUS:
                            flags_d[CRA_FLAGS_SW_W-1:0] =
                                pwdata[CRA_FLAGS_SW_W-1:0];
                        CRA_OFF_FADDR: faddr_d = pwdata[6:0];
                        CRA_OFF_FDATA: begin
                            mem_we = 1'b1;
                            mem_waddr = faddr_q;
                            mem_wdata = pwdata[7:0];
                        end
                        default: pslverr_d = 1'b1;
                    endcase
                end else begin
                    unique case (paddr)
                        CRA_OFF_CMD: prdata_d[CRA_CMD_W-1:0] = cmd_q;
                        CRA_OFF_ACC: prdata_d[7:0] = acc_q;
                        CRA_OFF_STATUS:
                            prdata_d[CRA_FLAGS_W-1:0] = flags_q;
                        CRA_OFF_FADDR: prdata_d[6:0] = faddr_q;
                        CRA_OFF_FDATA: prdata_d[7:0] = mem_rdata;
                        CRA_OFF_DIR:
                            prdata_d[23:0] = {dir_c_q, dir_b_q, dir_a_q};
                        CRA_OFF_WDOG:
                            prdata_d[PRE_W+7:0] = {pre_q, wdog_q};
                        CRA_OFF_STATE: prdata_d[1:0] = {osc_q, asleep_q};
                        default: pslverr_d = 1'b1;
                    endcase
                end
            end
            ST_DONE: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            cmd_q <= '0;
            flags_q <= CRA_FLAGS_RST;
            acc_q <= CRA_ACC_RST;
            faddr_q <= CRA_FADDR_RST;
            dir_a_q <= CRA_DIR_RST;
            dir_b_q <= CRA_DIR_RST;
            dir_c_q <= CRA_DIR_RST;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            asleep_q <= 1'b0;
            osc_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            flags_q <= flags_d;
            acc_q <= acc_d;
            faddr_q <= faddr_d;
            dir_a_q <= dir_a_d;
            dir_b_q <= dir_b_d;
            dir_c_q <= dir_c_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            asleep_q <= asleep_d;
            osc_q <= osc_d;
        end
    end

    // watchdog keeps counting while asleep, as a real one would
    always_comb begin
        pre_d = pre_q + 1'b1;
        wdog_d = wdog_q + {7'h00, &pre_q};
        if (sleep_go) begin
            pre_d = '0;
            wdog_d = CRA_WDOG_CLR;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
            wdog_q <= CRA_WDOG_CLR;
        end else begin
            pre_q <= pre_d;
            wdog_q <= wdog_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign port_a_direction = dir_a_q;
    assign port_b_direction = dir_b_q;
    assign port_c_direction = dir_c_q;
    assign osc_run = osc_q;
    assign cpu_halted = asleep_q;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_sleep;
        exec_go && cmd_in.op == OP_SLEEP;
    endsequence
    sequence s_cmd_asleep;
        st_q == ST_FETCH && pwrite && is_cmd && asleep_q && !wake_s_q;
    endsequence

    a_rotate_carry: assert property (
        exec_go && cmd_in.op == OP_ROTATE_RIGHT_CARRY && !cmd_in.dest |=>
        acc_q == {$past(flag_c), $past(mem_rdata[7:1])} &&
        flags_q.c == $past(mem_rdata[0]) && $stable(flags_q.z))
        else $error("rotate right result or carry wrong");
    a_dest_file: assert property (
        exec_go && reg_op && cmd_in.dest |-> mem_we ##1 $stable(acc_q))
        else $error("file destination not honoured");
    a_litsub_diff: assert property (
        exec_go && cmd_in.op == OP_LITERAL_MINUS_ACC |=>
        acc_q == 8'($past(cmd_lit) - $past(acc_q)))
        else $error("literal subtract result wrong");
    a_sub_carry_half: assert property (
        exec_go && cmd_in.op == OP_LITERAL_MINUS_ACC |=>
        flags_q.c == ($past(acc_q) <= $past(cmd_lit)) &&
        flags_q.half_borrow_flag ==
        ($past(acc_q[3:0]) <= $past(cmd_lit[3:0])))
        else $error("subtract carry or half borrow wrong");
    a_filesub_diff: assert property (
        exec_go && cmd_in.op == OP_FILE_MINUS_ACC && !cmd_in.dest |=>
        acc_q == 8'($past(mem_rdata) - $past(acc_q)))
        else $error("file subtract result wrong");
    a_borrowsub_diff: assert property (
        exec_go && cmd_in.op == OP_FILE_MINUS_ACC_BORROW && !cmd_in.dest |=>
        acc_q == 8'($past(mem_rdata) - $past(acc_q) - {7'h00, !$past(flag_c)}))
        else $error("borrow subtract result wrong");
    a_sleep_entry: assert property (
        s_sleep |=> wdog_q == CRA_WDOG_CLR && pre_q == '0 &&
        flags_q.expiry_flag_n && !flags_q.power_down_flag_n)
        else $error("sleep entry flags or watchdog wrong");
    a_sleep_halts: assert property (
        s_cmd_asleep |=> pslverr_q && $stable(acc_q) && $stable(flags_q) &&
        !osc_run && cpu_halted)
        else $error("command executed while asleep");
    a_swap_nibble: assert property (
        exec_go && cmd_in.op == OP_NIBBLE_EXCHANGE && !cmd_in.dest |=>
        acc_q == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} &&
        $stable(flags_q))
        else $error("nibble exchange wrong");
    a_xorlit_zero: assert property (
        exec_go && cmd_in.op == OP_XOR_LITERAL |=>
        acc_q == ($past(acc_q) ^ $past(cmd_lit)) &&
        flags_q.z == (acc_q == 8'h00) && flags_q.c == $past(flag_c))
        else $error("xor literal result or zero flag wrong");
    a_xorfile_zero: assert property (
        exec_go && cmd_in.op == OP_XOR_FILE && !cmd_in.dest |=>
        flags_q.z == (acc_q == 8'h00) && $stable(flags_q.half_borrow_flag))
        else $error("xor file zero flag wrong");
    a_dir_load_b: assert property (
        exec_go && cmd_in.op == OP_DIRECTION_LOAD &&
        cmd_in.faddr == CRA_DIR_B |=>
        port_b_direction == $past(acc_q) && $stable(port_a_direction))
        else $error("direction load wrong");
endmodule

//--- include/cra_pkg.sv
package cra_pkg;

    // apb geometry
    localparam int CRA_AW = 8;
    localparam int CRA_DW = 32;

    // register byte offsets
    localparam logic [7:0] CRA_OFF_CMD = 8'h00;
    localparam logic [7:0] CRA_OFF_ACC = 8'h04;
    localparam logic [7:0] CRA_OFF_STATUS = 8'h08;
    localparam logic [7:0] CRA_OFF_FADDR = 8'h0C;
    localparam logic [7:0] CRA_OFF_FDATA = 8'h10;
    localparam logic [7:0] CRA_OFF_DIR = 8'h14;
    localparam logic [7:0] CRA_OFF_WDOG = 8'h18;
    localparam logic [7:0] CRA_OFF_STATE = 8'h1C;

    // file register space and operand codes of the direction load
    localparam int CRA_FAW = 7;
    localparam logic [6:0] CRA_DIR_A = 7'h05;
    localparam logic [6:0] CRA_DIR_B = 7'h06;
    localparam logic [6:0] CRA_DIR_C = 7'h07;

    // watchdog
    localparam int CRA_PRE_W = 8;
    localparam logic [7:0] CRA_WDOG_CLR = 8'h00;

    // reset values
    localparam logic [7:0] CRA_ACC_RST = 8'h00;
    localparam logic [7:0] CRA_DIR_RST = 8'hFF;
    localparam logic [6:0] CRA_FADDR_RST = 7'h00;

    typedef enum logic [3:0] {
        OP_ROTATE_RIGHT_CARRY = 4'h0,
        OP_LITERAL_MINUS_ACC = 4'h1,
        OP_FILE_MINUS_ACC = 4'h2,
        OP_FILE_MINUS_ACC_BORROW = 4'h3,
        OP_NIBBLE_EXCHANGE = 4'h4,
        OP_XOR_LITERAL = 4'h5,
        OP_XOR_FILE = 4'h6,
        OP_DIRECTION_LOAD = 4'h7,
        OP_SLEEP = 4'h8
    } cra_op_e;

    // command word: op in [3:0], file address [10:4], dest [11], lit [19:12]
    typedef struct packed {
        logic [7:0] lit;
        logic dest;
        logic [6:0] faddr;
        cra_op_e op;
    } cra_cmd_s;
    localparam int CRA_CMD_W = 20;

    // status word: c in bit 0 upward; the two power flags are active low
    typedef struct packed {
        logic expiry_flag_n;
        logic power_down_flag_n;
        logic z;
        logic half_borrow_flag;
        logic c;
    } cra_flags_s;
    localparam int CRA_FLAGS_W = 5;
    localparam int CRA_FLAGS_SW_W = 3;
    localparam cra_flags_s CRA_FLAGS_RST = 5'h18;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_DONE = 2'b10
    } cra_state_e;

endpackage

//--- src/cra_file_mem.sv
`timescale 1ns/1ps
module cra_file_mem #(
    parameter int AW = 7,
    parameter int DW = 8
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // read port, data one edge after the address
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem_q [2**AW];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
        rdata_q <= mem_q[raddr];
    end

    assign rdata = rdata_q;
endmodule

//--- sim/cpu_alu_rotate_sub_xor_ops_bench.sv
`timescale 1ns/1ps
module cpu_alu_rotate_sub_xor_ops_bench
    import cra_pkg::*;
;
    logic pclk;
    logic presetn;
    logic [CRA_AW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [CRA_DW-1:0] pwdata;
    logic [CRA_DW-1:0] prdata;
    logic pready;
    logic pslverr;
    logic wake_pin;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    logic osc_run;
    logic cpu_halted;
    int error_cnt;
    int checks;

    // short prescaler keeps the watchdog visibly moving in a short run
    cra_alu_core #(.PRE_W(4)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wake_pin(wake_pin), .port_a_direction(port_a_direction),
        .port_b_direction(port_b_direction),
        .port_c_direction(port_c_direction), .osc_run(osc_run),
        .cpu_halted(cpu_halted)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_err(input logic got, input logic exp,
                           input string what);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s response %b", $time, what, got);
        end
    endtask

    // setup, then access held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            $display("[FAIL] %0t no bus answer", $time);
            conclude();
        end
    endtask

    // returns {result, z, half borrow, c, result goes to accumulator}
    function automatic logic [11:0] model(input logic [3:0] op,
        input logic [7:0] f, input logic [7:0] a, input logic [7:0] k,
        input logic dst, input logic [2:0] fl);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] m;
        logic [7:0] r;
        logic c, hb, z, b, to_acc;
        c = fl[0];
        hb = fl[1];
        z = fl[2];
        to_acc = !dst;
        b = (op == 4'h3) ? ~c : 1'b0;
        m = (op == 4'h1) ? k : f;
        d = {1'b0, m} - {1'b0, a} - {8'h00, b};
        h = {1'b0, m[3:0]} - {1'b0, a[3:0]} - {4'h0, b};
        r = 8'h00;
        case (op)
            4'h0: begin
                r = {c, f[7:1]};
                c = f[0];
            end
            4'h1, 4'h2, 4'h3: begin
                r = d[7:0];
                c = ~d[8];
                hb = ~h[4];
                z = (r == 8'h00);
                if (op == 4'h1) to_acc = 1'b1;
            end
            4'h4: r = {f[3:0], f[7:4]};
            4'h5: begin
                r = a ^ k;
                z = (r == 8'h00);
                to_acc = 1'b1;
            end
            default: begin
                r = a ^ f;
                z = (r == 8'h00);
            end
        endcase
        return {r, z, hb, c, to_acc};
    endfunction

    initial begin : main
        logic [31:0] rd;
        logic er;
        logic [7:0] f, a, k;
        logic [6:0] fa;
        logic [3:0] op;
        logic dst;
        logic [2:0] fl;
        logic [11:0] e;
        logic [23:0] dirs;
        int n;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wake_pin = 1'b0;
        error_cnt = 0;
        checks = 0;
        void'($urandom(67));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CRA_OFF_ACC, 32'h0, rd, er);
        cmp(rd, 32'h0, "acc reset");
        apb(1'b0, CRA_OFF_STATUS, 32'h0, rd, er);
        cmp(rd, 32'h18, "status reset");
        apb(1'b0, CRA_OFF_DIR, 32'h0, rd, er);
        cmp(rd, 32'h00FFFFFF, "dir reset");
        apb(1'b0, CRA_OFF_STATE, 32'h0, rd, er);
        cmp(rd, 32'h2, "state reset");
        apb(1'b0, 8'h20, 32'h0, rd, er);
        cmp_err(er, 1'b1, "unmapped read");
        cmp(rd, 32'h0, "unmapped data");
        apb(1'b1, 8'h24, 32'hFFFF_FFFF, rd, er);
        cmp_err(er, 1'b1, "unmapped write");
        // first rows are all-zero and nibble-borrow corners, then random
        for (int i = 0; i < 84; i++) begin
            op = 4'(i % 7);
            f = (i < 7) ? 8'h00 : (i < 14) ? 8'hF0 : 8'($urandom);
            a = (i < 7) ? 8'h00 : (i < 14) ? 8'h0F : 8'($urandom);
            k = (i < 7) ? 8'h00 : (i < 14) ? 8'h10 : 8'($urandom);
            fa = 7'($urandom);
            dst = 1'($urandom);
            fl = 3'($urandom);
            apb(1'b1, CRA_OFF_FADDR, {25'h0, fa}, rd, er);
            apb(1'b1, CRA_OFF_FDATA, {24'h0, f}, rd, er);
            apb(1'b1, CRA_OFF_ACC, {24'h0, a}, rd, er);
            apb(1'b1, CRA_OFF_STATUS, {29'h0, fl}, rd, er);
            apb(1'b1, CRA_OFF_CMD, {12'h0, k, dst, fa, op}, rd, er);
            cmp_err(er, 1'b0, "exec response");
            e = model(op, f, a, k, dst, fl);
            apb(1'b0, CRA_OFF_ACC, 32'h0, rd, er);
            cmp(rd, {24'h0, e[0] ? e[11:4] : a}, "acc");
            apb(1'b0, CRA_OFF_FDATA, 32'h0, rd, er);
            cmp(rd, {24'h0, e[0] ? f : e[11:4]}, "file");
            apb(1'b0, CRA_OFF_STATUS, 32'h0, rd, er);
            cmp(rd, {29'h3, e[3:1]}, "flags");
        end
        dirs = 24'hFFFFFF;
        for (int j = 0; j < 3; j++) begin
            a = 8'($urandom);
            apb(1'b1, CRA_OFF_ACC, {24'h0, a}, rd, er);
            apb(1'b1, CRA_OFF_STATUS, 32'h5, rd, er);
            apb(1'b1, CRA_OFF_CMD, {21'h0, CRA_DIR_A + 7'(j), 4'h7},
                rd, er);
            cmp_err(er, 1'b0, "direction load");
            dirs[j*8 +: 8] = a;
            cmp({8'h0, port_c_direction, port_b_direction,
                 port_a_direction}, {8'h0, dirs}, "dir pins");
            apb(1'b0, CRA_OFF_STATUS, 32'h0, rd, er);
            cmp(rd, 32'h1D, "dir flags");
        end
        // operand outside 5..7 must be refused without touching the ports
        apb(1'b1, CRA_OFF_CMD, {21'h0, 7'h04, 4'h7}, rd, er);
        cmp_err(er, 1'b1, "bad operand");
        apb(1'b0, CRA_OFF_DIR, 32'h0, rd, er);
        cmp(rd, {8'h0, dirs}, "dir kept");
        apb(1'b1, CRA_OFF_CMD, 32'h9, rd, er);
        cmp_err(er, 1'b1, "illegal op");
        apb(1'b0, CRA_OFF_CMD, 32'h0, rd, er);
        cmp(rd, {21'h0, CRA_DIR_C, 4'h7}, "last command");
        repeat (100) @(posedge pclk);
        apb(1'b0, CRA_OFF_WDOG, 32'h0, rd, er);
        cmp({31'h0, rd[7:0] != 8'h00}, 32'h1, "watchdog runs");
        apb(1'b1, CRA_OFF_CMD, {28'h0, 4'h8}, rd, er);
        cmp_err(er, 1'b0, "sleep");
        apb(1'b0, CRA_OFF_WDOG, 32'h0, rd, er);
        cmp({24'h0, rd[7:0]}, 32'h0, "watchdog cleared");
        // three edges pass between the clear and the sampling edge
        cmp({24'h0, rd[15:8]}, 32'h3, "prescaler cleared");
        apb(1'b0, CRA_OFF_STATUS, 32'h0, rd, er);
        cmp({30'h0, rd[4:3]}, 32'h2, "power flags");
        cmp({30'h0, osc_run, cpu_halted}, 32'h1, "asleep pins");
        apb(1'b1, CRA_OFF_CMD, {12'h0, 8'h5A, 8'h0, 4'h5}, rd, er);
        cmp_err(er, 1'b1, "exec while asleep");
        wake_pin <= 1'b1;
        n = 0;
        while (cpu_halted !== 1'b0 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 10) begin
            error_cnt++;
            $display("[FAIL] %0t no wake", $time);
            conclude();
        end
        wake_pin <= 1'b0;
        @(posedge pclk);
        cmp({31'h0, osc_run}, 32'h1, "oscillator back");
        apb(1'b0, CRA_OFF_STATE, 32'h0, rd, er);
        cmp(rd, 32'h2, "state awake");
        apb(1'b0, CRA_OFF_STATUS, 32'h0, rd, er);
        cmp({30'h0, rd[4:3]}, 32'h2, "flags after wake");
        conclude();
    end
endmodule
